// ### pwmdb_pkg.sv
// Package of constants and types for the dead-band pulse generator
package pwmdb_pkg;
    localparam int CNT_W = 16;

    // Register byte offsets (one aligned word each)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_LOAD    = 8'h04;
    localparam logic [7:0] OFS_CMPA    = 8'h08;
    localparam logic [7:0] OFS_CMPB    = 8'h0c;
    localparam logic [7:0] OFS_ACTA    = 8'h10;
    localparam logic [7:0] OFS_ACTB    = 8'h14;
    localparam logic [7:0] OFS_DBCTL   = 8'h18;
    localparam logic [7:0] OFS_DBRISE  = 8'h1c;
    localparam logic [7:0] OFS_DBFALL  = 8'h20;
    localparam logic [7:0] OFS_EVSEL   = 8'h24;
    localparam logic [7:0] OFS_GLOBAL  = 8'h28;
    localparam logic [7:0] OFS_COUNT   = 8'h2c;
    localparam logic [7:0] OFS_STATUS  = 8'h30;

    // Control register field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_UPDOWN = 1;
    localparam int CTRL_SYNCUP = 2;
    localparam int CTRL_DBGRUN = 3;
    localparam int CTRL_FLTA   = 4;
    localparam int CTRL_FLTB   = 5;
    localparam int CTRL_FLTIE  = 6;
    localparam int CTRL_W      = 7;

    // Global register field positions
    localparam int GLB_RESET  = 0;
    localparam int GLB_UPDATE = 1;

    // Event index positions in selection masks and action words
    localparam int EV_ZERO  = 0;
    localparam int EV_LOAD  = 1;
    localparam int EV_AUP   = 2;
    localparam int EV_ADOWN = 3;
    localparam int EV_BUP   = 4;
    localparam int EV_BDOWN = 5;
    localparam int EV_N     = 6;
    localparam int EVSEL_TRIG = 8;

    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    typedef enum logic [1:0]
    {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_LOW    = 2'b10,
        ACT_HIGH   = 2'b11
    } pwmdb_act_type;

    typedef struct packed
    {
        logic zero;
        logic load;
        logic aUp;
        logic aDown;
        logic bUp;
        logic bDown;
    } pwmdb_events_type;

    typedef struct packed
    {
        logic [CNT_W-1:0] load;
        logic [CNT_W-1:0] cmpA;
        logic [CNT_W-1:0] cmpB;
    } pwmdb_params_type;
endpackage : pwmdb_pkg

// ### pwmdb_generator.sv
// One pulse-width generator with comparators, actions, dead-band and APB registers
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module pwmdb_generator
    import pwmdb_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              globalResetIn,
    input  wire logic              globalUpdateIn,
    input  wire logic              faultIn,
    input  wire logic              debugStall,
    output logic                   firstOut,
    output logic                   secondOut,
    output logic                   irqReq,
    output logic                   adcTrig
);

    function automatic logic applyAct(input logic cur, input logic [1:0] act);
        unique case (act)
            ACT_NONE:   applyAct = cur;
            ACT_TOGGLE: applyAct = ~cur;
            ACT_LOW:    applyAct = 1'b0;
            ACT_HIGH:   applyAct = 1'b1;
        endcase
    endfunction : applyAct

    // Two-bit action field of one event within a packed action word
    function automatic logic [1:0] actOf(input logic [11:0] acts, input int idx);
        actOf = acts[2*idx +: 2];
    endfunction : actOf

    // A compare value above the load can never match
    function automatic logic cmpHit(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp,
                                    input logic [CNT_W-1:0] lim);
        cmpHit = (cnt == cmp) && (cmp <= lim);
    endfunction : cmpHit

    // Saturating step towards zero
    function automatic logic [CNT_W-1:0] stepDown(input logic [CNT_W-1:0] v);
        stepDown = (v == CNT_RESET) ? CNT_RESET : v - 16'h0001;
    endfunction : stepDown

    logic [CTRL_W-1:0]    ctrl_r;
    pwmdb_params_type     shadow_r;
    pwmdb_params_type     active_r;
    logic                 syncArmed_r;
    logic [11:0]          actA_r;
    logic [11:0]          actB_r;
    logic                 dbEn_r;
    logic [CNT_W-1:0]     dbRise_r;
    logic [CNT_W-1:0]     dbFall_r;
    logic [15:0]          evSel_r;
    logic [CNT_W-1:0]     count_r;
    logic                 dir_r;
    logic                 halted_r;
    logic                 genA_r;
    logic                 genB_r;
    logic [CNT_W-1:0]     riseCnt_r;
    logic [CNT_W-1:0]     fallCnt_r;
    logic                 dbA_r;
    logic                 dbB_r;
    logic                 dbInPrev_r;
    logic                 firstOut_r;
    logic                 secondOut_r;
    logic                 irq_r;
    logic                 trig_r;
    logic                 fltIrq_r;
    logic [31:0]          prdata_r;

    // Read data is captured in the setup cycle, so it stands through the access phase;
    // the price is that a read shows state one clock before its access edge
    wire                  apbWr      = psel && penable && pwrite;
    wire                  apbRd      = psel && !penable && !pwrite;
    wire                  enabled    = ctrl_r[CTRL_EN];
    wire                  upDown     = ctrl_r[CTRL_UPDOWN];
    wire                  atZero     = (count_r == CNT_RESET);
    wire                  atLoad     = (count_r == active_r.load);
    wire                  stallHalt  = debugStall && !ctrl_r[CTRL_DBGRUN];
    wire                  running    = enabled && !halted_r && !(stallHalt && atZero);
    // A fresh parameter write drops a pending arm so old and new values never mix
    wire                  paramWr    = apbWr && (paddr == OFS_LOAD || paddr == OFS_CMPA
                                                 || paddr == OFS_CMPB);
    wire                  wrGlobal   = apbWr && paddr == OFS_GLOBAL;
    wire                  gResetHit  = wrGlobal && pwdata[GLB_RESET];
    wire                  gUpdHit    = wrGlobal && pwdata[GLB_UPDATE];
    wire                  doReset    = globalResetIn || gResetHit;
    wire                  doUpdate   = globalUpdateIn || gUpdHit;
    wire                  loadParams = running && atZero && (!ctrl_r[CTRL_SYNCUP] || syncArmed_r);

    // Raw events; only meaningful while the counter is enabled
    wire                  evZero     = enabled && atZero;
    wire                  evLoad     = enabled && atLoad;
    wire                  mA         = enabled && cmpHit(count_r, active_r.cmpA, active_r.load);
    wire                  mB         = enabled && cmpHit(count_r, active_r.cmpB, active_r.load);
    wire                  evAUp      = mA && upDown && dir_r;
    wire                  evADown    = mA && !(upDown && dir_r);
    wire                  evBUp      = mB && upDown && dir_r;
    wire                  evBDown    = mB && !(upDown && dir_r);
    wire                  matchOk    = !evZero && !evLoad;
    // Raw events as one carrier, reordered below into the selector bit order
    pwmdb_events_type     evRaw;
    assign evRaw = '{zero: evZero, load: evLoad, aUp: evAUp, aDown: evADown,
                     bUp: evBUp, bDown: evBDown};
    wire [EV_N-1:0]       evVec      = {evRaw.bDown, evRaw.bUp, evRaw.aDown, evRaw.aUp,
                                        evRaw.load, evRaw.zero};

    // Zero applied first, load next so it overrides; matches only apply in cycles with neither event
    logic                 genANxt;
    logic                 genBNxt;
    always_comb
    begin
        genANxt = genA_r;
        genBNxt = genB_r;
        if (evZero)
        begin
            genANxt = applyAct(genANxt, actOf(actA_r, EV_ZERO));
            genBNxt = applyAct(genBNxt, actOf(actB_r, EV_ZERO));
        end
        if (evLoad)
        begin
            genANxt = applyAct(genANxt, actOf(actA_r, EV_LOAD));
            genBNxt = applyAct(genBNxt, actOf(actB_r, EV_LOAD));
        end
        // Each output also follows the other comparator, unless its own one matches too
        if (matchOk)
        begin
            if (evAUp)
                genANxt = applyAct(genANxt, actOf(actA_r, EV_AUP));
            if (evADown)
                genANxt = applyAct(genANxt, actOf(actA_r, EV_ADOWN));
            if (evBUp && !mA)
                genANxt = applyAct(genANxt, actOf(actA_r, EV_BUP));
            if (evBDown && !mA)
                genANxt = applyAct(genANxt, actOf(actA_r, EV_BDOWN));
            if (evBUp)
                genBNxt = applyAct(genBNxt, actOf(actB_r, EV_BUP));
            if (evBDown)
                genBNxt = applyAct(genBNxt, actOf(actB_r, EV_BDOWN));
            if (evAUp && !mB)
                genBNxt = applyAct(genBNxt, actOf(actB_r, EV_AUP));
            if (evADown && !mB)
                genBNxt = applyAct(genBNxt, actOf(actB_r, EV_ADOWN));
        end
    end

    // Counter next value
    logic [CNT_W-1:0]     countNxt;
    logic                 dirNxt;
    always_comb
    begin
        countNxt = count_r;
        dirNxt   = dir_r;
        if (!upDown)
        begin
            dirNxt   = 1'b0;
            countNxt = atZero ? active_r.load : count_r - 16'h0001;
        end
        else if (dir_r)
        begin
            if (atLoad || count_r > active_r.load)
            begin
                dirNxt   = 1'b0;
                countNxt = stepDown(count_r);
            end
            else
                countNxt = count_r + 16'h0001;
        end
        else
        begin
            if (atZero)
            begin
                dirNxt   = 1'b1;
                countNxt = (active_r.load == CNT_RESET) ? CNT_RESET : 16'h0001;
            end
            else
                countNxt = count_r - 16'h0001;
        end
    end

    // Dead-band: count out the delay after each input edge
    wire                  dbIn       = genA_r;
    wire                  dbRiseEdge = dbIn && !dbInPrev_r;
    wire                  dbFallEdge = !dbIn && dbInPrev_r;
    wire                  dbANxt     = !dbIn ? 1'b0
                                     : (dbRiseEdge ? (dbRise_r == CNT_RESET)
                                     : (dbA_r || riseCnt_r == 16'h0001));
    wire                  dbBNxt     = dbIn ? 1'b0
                                     : (dbFallEdge ? (dbFall_r == CNT_RESET)
                                     : (dbB_r || fallCnt_r == 16'h0001));
    // A delay of zero still costs the one register stage that every output has
    wire [CNT_W-1:0]      riseCntNxt = dbRiseEdge ? dbRise_r : stepDown(riseCnt_r);
    wire [CNT_W-1:0]      fallCntNxt = dbFallEdge ? dbFall_r : stepDown(fallCnt_r);
    wire                  rawA       = dbEn_r ? dbA_r : genA_r;
    wire                  rawB       = dbEn_r ? dbB_r : genB_r;
    wire                  outANxt    = rawA && !(faultIn && ctrl_r[CTRL_FLTA]);
    wire                  outBNxt    = rawB && !(faultIn && ctrl_r[CTRL_FLTB]);
    wire                  irqNxt     = |(evVec & evSel_r[EV_N-1:0]);
    wire                  trigNxt    = |(evVec & evSel_r[EVSEL_TRIG +: EV_N]);

    // Unmapped offsets read as zero
    logic [31:0]          rdMux;
    always_comb
    begin
        unique case (paddr)
            OFS_CTRL:   rdMux = {25'h0, ctrl_r};
            OFS_LOAD:   rdMux = {16'h0, shadow_r.load};
            OFS_CMPA:   rdMux = {16'h0, shadow_r.cmpA};
            OFS_CMPB:   rdMux = {16'h0, shadow_r.cmpB};
            OFS_ACTA:   rdMux = {20'h0, actA_r};
            OFS_ACTB:   rdMux = {20'h0, actB_r};
            OFS_DBCTL:  rdMux = {31'h0, dbEn_r};
            OFS_DBRISE: rdMux = {16'h0, dbRise_r};
            OFS_DBFALL: rdMux = {16'h0, dbFall_r};
            OFS_EVSEL:  rdMux = {16'h0, evSel_r};
            OFS_COUNT:  rdMux = {16'h0, count_r};
            OFS_STATUS: rdMux = {27'h0, fltIrq_r, halted_r, syncArmed_r, dir_r, faultIn};
            default:    rdMux = 32'h0;
        endcase
    end
    wire                  addrOk     = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_r   <= '0;
            shadow_r <= '0;
            actA_r   <= '0;
            actB_r   <= '0;
            dbEn_r   <= 1'b0;
            dbRise_r <= '0;
            dbFall_r <= '0;
            evSel_r  <= '0;
            prdata_r <= '0;
        end
        else if (clkEn)
        begin
            if (apbRd)
                prdata_r <= addrOk ? rdMux : 32'h0;
            // The global register acts on the write itself and keeps no storage
            if (apbWr)
            begin
                unique case (paddr)
                    OFS_CTRL:   ctrl_r        <= pwdata[CTRL_W-1:0];
                    OFS_LOAD:   shadow_r.load <= pwdata[15:0];
                    OFS_CMPA:   shadow_r.cmpA <= pwdata[15:0];
                    OFS_CMPB:   shadow_r.cmpB <= pwdata[15:0];
                    OFS_ACTA:   actA_r        <= pwdata[11:0];
                    OFS_ACTB:   actB_r        <= pwdata[11:0];
                    OFS_DBCTL:  dbEn_r        <= pwdata[0];
                    OFS_DBRISE: dbRise_r      <= pwdata[15:0];
                    OFS_DBFALL: dbFall_r      <= pwdata[15:0];
                    OFS_EVSEL:  evSel_r       <= pwdata[15:0];
                    default:    ;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            active_r    <= '0;
            syncArmed_r <= 1'b0;
            count_r     <= CNT_RESET;
            dir_r       <= 1'b0;
            halted_r    <= 1'b0;
        end
        else if (clkEn)
        begin
            if (loadParams)
                active_r <= shadow_r;
            // Arm survives a same-cycle consumption so an update is never lost
            if (doUpdate)
                syncArmed_r <= 1'b1;
            else if (loadParams || paramWr)
                syncArmed_r <= 1'b0;
            halted_r <= enabled && stallHalt && (halted_r || atZero);
            if (doReset)
            begin
                count_r <= CNT_RESET;
                dir_r   <= 1'b0;
            end
            else if (running)
            begin
                count_r <= countNxt;
                dir_r   <= dirNxt;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            genA_r      <= 1'b0;
            genB_r      <= 1'b0;
            dbInPrev_r  <= 1'b0;
            dbA_r       <= 1'b0;
            dbB_r       <= 1'b0;
            riseCnt_r   <= '0;
            fallCnt_r   <= '0;
            firstOut_r  <= 1'b0;
            secondOut_r <= 1'b0;
            irq_r       <= 1'b0;
            trig_r      <= 1'b0;
            fltIrq_r    <= 1'b0;
        end
        else if (clkEn)
        begin
            // Events are taken only on counter steps, so a halted timer holds outputs
            if (running || !enabled)
            begin
                genA_r <= genANxt;
                genB_r <= genBNxt;
            end
            dbInPrev_r  <= dbIn;
            dbA_r       <= dbANxt;
            dbB_r       <= dbBNxt;
            riseCnt_r   <= riseCntNxt;
            fallCnt_r   <= fallCntNxt;
            firstOut_r  <= outANxt;
            secondOut_r <= outBNxt;
            irq_r       <= running && irqNxt;
            trig_r      <= running && trigNxt;
            fltIrq_r    <= faultIn && ctrl_r[CTRL_FLTIE];
        end
    end

    assign prdata    = prdata_r;
    // Zero wait states: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addrOk;
    assign firstOut  = firstOut_r;
    assign secondOut = secondOut_r;
    assign irqReq    = irq_r || fltIrq_r;
    assign adcTrig   = trig_r;

endmodule : pwmdb_generator

// ### pwmdb_props.sv
// Port-level checker for the pulse generator, bound to the generator
`timescale 1ns/100ps
module pwmdb_props
    import pwmdb_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        globalResetIn,
    input wire logic        globalUpdateIn,
    input wire logic        faultIn,
    input wire logic        debugStall,
    input wire logic        firstOut,
    input wire logic        secondOut,
    input wire logic        irqReq,
    input wire logic        adcTrig
);
    logic [CTRL_W-1:0] ctrl_r;
    logic              dbOn_r;
    wire               acc = psel && penable;
    wire               badAddr = (paddr[1:0] != 2'h0) || (paddr > OFS_STATUS);
    wire               wrHit = acc && pwrite && clkEn;

    // Shadow of the written control bits, so fault checks know what is armed
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_r <= '0;
            dbOn_r <= 1'h0;
        end
        else
        begin
            if (wrHit && paddr == OFS_CTRL)
                ctrl_r <= pwdata[CTRL_W-1:0];
            if (wrHit && paddr == OFS_DBCTL)
                dbOn_r <= pwdata[0];
        end
    end

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_reset_quiet: assert property (disable iff (1'h0) !rst_n |=> !firstOut && !secondOut
        && !irqReq && !adcTrig && prdata == 32'h0) else $error("outputs not cleared");
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_bad: assert property (acc && badAddr |-> pslverr) else $error("no slave error");
    a_err_none: assert property (acc && !badAddr |-> !pslverr) else $error("spurious error");
    a_err_rdzero: assert property (psel && !penable && !pwrite && badAddr && clkEn
        |=> prdata == 32'h0)
        else $error("refused read not zero");
    a_freeze_hold: assert property (!clkEn |=> $stable({firstOut, secondOut, adcTrig, prdata}))
        else $error("state moved while frozen");
    a_fault_force: assert property (
        (faultIn && clkEn && ctrl_r[CTRL_FLTA]) [*3] |-> !firstOut)
        else $error("fault did not force first output low");
    a_fault_irq: assert property (
        faultIn && clkEn && ctrl_r[CTRL_FLTIE] |=> irqReq) else $error("fault irq missing");
    // Four cycles of grace let the pair settle after dead-band is switched on
    a_db_apart: assert property (
        dbOn_r && $past(dbOn_r, 4) |-> !(firstOut && secondOut))
        else $error("both dead-band outputs high");
endmodule : pwmdb_props

bind pwmdb_generator pwmdb_props pwmdb_props_inst
(
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .globalResetIn(globalResetIn), .globalUpdateIn(globalUpdateIn),
    .faultIn(faultIn), .debugStall(debugStall), .firstOut(firstOut),
    .secondOut(secondOut), .irqReq(irqReq), .adcTrig(adcTrig)
);

// ### pwmdb_gate_model.sv
// Gate-driver side model: counts the on-time of each switch of the pair
`timescale 1ns/100ps
module pwmdb_gate_model
(
    input  wire logic clock,
    input  wire logic clear,
    input  wire logic highSide,
    input  wire logic lowSide,
    output int        highCount,
    output int        lowCount
);
    // An unknown level counts as off, so it can never pass for on-time
    always @(posedge clock)
    begin
        highCount <= clear ? 0 : highCount + int'(highSide === 1'h1);
        lowCount  <= clear ? 0 : lowCount + int'(lowSide === 1'h1);
    end
endmodule : pwmdb_gate_model

// ### test_pwmdb_generator.sv
// Self-checking bench for the dead-band pulse generator
`timescale 1ns/100ps
module test_pwmdb_generator
    import pwmdb_pkg::*;
();
    logic        clock = 1'h0, rst_n = 1'h0, clkEn = 1'h1, clear = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdSeen;
    logic        globalResetIn = 1'h0, globalUpdateIn = 1'h0;
    logic        faultIn = 1'h0, debugStall = 1'h0;
    logic        pready, pslverr, firstOut, secondOut, irqReq, adcTrig, errSeen, hadIrq;
    int          highCount, lowCount, n;
    int          badCount = 0;
    int          checked = 0;
    // CTRL LOAD CMPA CMPB ACTA ACTB DBCTL DBRISE DBFALL, then on-time of each output
    logic [15:0] rows [10][11] = '{
        '{16'h1, 16'h4, 16'h2, 16'h2, 16'hc2, 16'hc02, 16'h0, 16'h0, 16'h0, 16'h10, 16'h10},
        '{16'h1, 16'h4, 16'h2, 16'h2, 16'hc2, 16'hc2, 16'h0, 16'h0, 16'h0, 16'h10, 16'h0},
        '{16'h1, 16'h4, 16'h2, 16'h2, 16'h1, 16'h2, 16'h0, 16'h0, 16'h0, 16'h14, 16'h0},
        '{16'h1, 16'h4, 16'h6, 16'h6, 16'hc2, 16'hc02, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
        '{16'h1, 16'h4, 16'h0, 16'h4, 16'hc0, 16'hc00, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
        '{16'h1, 16'h4, 16'h2, 16'h2, 16'h30, 16'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'h28},
        '{16'h3, 16'h4, 16'h2, 16'h3, 16'hb0, 16'hb00, 16'h0, 16'h0, 16'h0, 16'h14, 16'ha},
        '{16'h1, 16'h9, 16'h4, 16'h0, 16'hc2, 16'h2, 16'h1, 16'h2, 16'h1, 16'h8, 16'h14},
        '{16'h1, 16'h9, 16'h4, 16'h0, 16'hc2, 16'h2, 16'h1, 16'h0, 16'h0, 16'h10, 16'h18},
        '{16'h1, 16'h4, 16'h2, 16'h3, 16'hc02, 16'hc2, 16'h0, 16'h0, 16'h0, 16'h18, 16'h10}};

    always #25 clock = ~clock;

    pwmdb_generator pwmdb_generator_inst
    (
        .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .globalResetIn(globalResetIn), .globalUpdateIn(globalUpdateIn),
        .faultIn(faultIn), .debugStall(debugStall), .firstOut(firstOut),
        .secondOut(secondOut), .irqReq(irqReq), .adcTrig(adcTrig)
    );
    pwmdb_gate_model pwmdb_gate_model_inst
    (
        .clock(clock), .clear(clear), .highSide(firstOut), .lowSide(secondOut),
        .highCount(highCount), .lowCount(lowCount)
    );

    task automatic closeOut();
        $display("checked %0d mismatched %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : closeOut

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read data stands through the access phase and is taken at the edge that samples pready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do @(posedge clock); while (pready !== 1'h1 && ++n < 16);
        if (pready !== 1'h1)
        begin
            badCount++;
            closeOut();
        end
        errSeen = pslverr;
        rdSeen = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask : xfer

    // Counts edges up to the next trigger; hadIrq is the level one edge before it
    task automatic wait_trig();
        n = 0;
        do
        begin
            hadIrq = irqReq;
            @(posedge clock);
        end
        while (adcTrig !== 1'h1 && ++n < 60);
        if (adcTrig !== 1'h1)
        begin
            badCount++;
            closeOut();
        end
        n++;
    endtask : wait_trig

    task automatic test_regs();
        xfer(OFS_CTRL, 1'h0, 32'h0);
        check(rdSeen, 32'h0);
        xfer(OFS_LOAD, 1'h1, 32'hffffabcd);
        xfer(OFS_LOAD, 1'h0, 32'h0);
        check(rdSeen, 32'h0000abcd);
        xfer(OFS_LOAD, 1'h1, 32'h4);
        xfer(8'h34, 1'h0, 32'h0);
        check(errSeen, 1'h1);
        check(rdSeen, 32'h0);
        xfer(8'h05, 1'h1, 32'h1);
        check(errSeen, 1'h1);
        $display("test regs done");
    endtask : test_regs

    // CTRL goes last so every row starts with its parameters in place
    task automatic test_actions();
        for (int r = 0; r < 10; r++)
        begin
            for (int k = 8; k >= 0; k--)
                xfer(8'(4 * k), 1'h1, 32'(rows[r][k]));
            repeat (24) @(posedge clock);
            clear <= 1'h1;
            @(posedge clock);
            clear <= 1'h0;
            repeat (41) @(posedge clock);
            check(32'(highCount), 32'(rows[r][9]));
            check(32'(lowCount), 32'(rows[r][10]));
        end
        $display("test actions done");
    endtask : test_actions

    task automatic test_timing();
        xfer(OFS_DBCTL, 1'h1, 32'h0);
        xfer(OFS_EVSEL, 1'h1, 32'h201);
        xfer(OFS_LOAD, 1'h1, 32'h4);
        repeat (24) @(posedge clock);
        wait_trig();
        wait_trig();
        check(n, 5);
        check({hadIrq, irqReq}, 2'h2);
        globalResetIn <= 1'h1;
        @(posedge clock);
        globalResetIn <= 1'h0;
        @(posedge clock);
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clock);
            check(irqReq, k == 0 || k == 5);
        end
        xfer(OFS_CTRL, 1'h1, 32'h5);
        xfer(OFS_LOAD, 1'h1, 32'h9);
        repeat (30) @(posedge clock);
        wait_trig();
        wait_trig();
        check(n, 5);
        globalUpdateIn <= 1'h1;
        @(posedge clock);
        globalUpdateIn <= 1'h0;
        repeat (30) @(posedge clock);
        wait_trig();
        wait_trig();
        check(n, 10);
        $display("test timing done");
    endtask : test_timing

    task automatic test_stall();
        debugStall <= 1'h1;
        for (int m = 0; m < 2; m++)
        begin
            xfer(OFS_CTRL, 1'h1, m ? 32'h1 : 32'h9);
            repeat (20) @(posedge clock);
            n = 0;
            repeat (40) @(posedge clock) n += int'(irqReq === 1'h1);
            check(n, m ? 0 : 4);
        end
        debugStall <= 1'h0;
        clkEn <= 1'h0;
        repeat (4) @(posedge clock);
        clkEn <= 1'h1;
        xfer(OFS_EVSEL, 1'h1, 32'h0);
        xfer(OFS_CTRL, 1'h1, 32'h51);
        xfer(OFS_LOAD, 1'h1, 32'h4);
        xfer(OFS_ACTA, 1'h1, 32'h3);
        xfer(OFS_ACTB, 1'h1, 32'h3);
        repeat (24) @(posedge clock);
        check({firstOut, secondOut, irqReq}, 3'h6);
        faultIn <= 1'h1;
        repeat (4) @(posedge clock);
        check({firstOut, secondOut, irqReq}, 3'h3);
        faultIn <= 1'h0;
        repeat (12) @(posedge clock);
        check({firstOut, secondOut, irqReq}, 3'h6);
        $display("test stall and fault done");
    endtask : test_stall

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        test_regs();
        test_actions();
        test_timing();
        test_stall();
        closeOut();
    end
endmodule : test_pwmdb_generator
